//--- tb/smt_march_gen_properties.sv
// pin-level checks on the sram pattern generator
`timescale 1ns/1ns
`include "smt_params.svh"
module smt_march_gen_properties
  import smt_pkg::*;
#(
  parameter int ROW_W = `SMT_ROW_W,
  parameter int WALK_W = `SMT_ADDR_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic test_sel,
  input wire logic [`SMT_DATA_W-1:0] sram_din,
  input wire smt_pins_t sram_pins,
  input wire logic busy,
  input wire logic done,
  input wire logic fail,
  input wire logic [`SMT_ADDR_W-1:0] fail_addr,
  input wire logic [`SMT_DATA_W-1:0] fail_data
);
  default clocking dclk @(posedge clk); endclocking
  default disable iff (srst);
  logic mode_q;
  logic [`SMT_ADDR_W-1:0] wa_q;

  // ==========
  // helper state
  // test kind latched when a run is taken
  always_ff @(posedge clk) begin
    if (srst)
      mode_q <= 1'b0;
    else if (!busy && start)
      mode_q <= test_sel;
  end

  // address of the last write strobe, for the order check
  always_ff @(posedge clk) begin
    if (!sram_pins.we_n)
      wa_q <= sram_pins.addr;
  end

  // ==========
  // properties
  property p_take; !busy && start |=> busy; endproperty
  a_take: assert property (p_take)
    else $error("start was not taken");
  property p_idle; !busy |-> sram_pins.we_n && sram_pins.oe_n; endproperty
  a_idle: assert property (p_idle)
    else $error("strobe while idle");
  property p_we_len;
    $fell(sram_pins.we_n) |=> !sram_pins.we_n ##1 sram_pins.we_n;
  endproperty
  a_we_len: assert property (p_we_len)
    else $error("write strobe length wrong");
  property p_wr_hold;
    !sram_pins.we_n |-> $stable(sram_pins.addr) && $stable(sram_pins.dout)
      && sram_pins.doe && !sram_pins.cs_n;
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write address or data moved");
  property p_rd_sel;
    !sram_pins.oe_n |-> sram_pins.we_n && !sram_pins.doe && sram_pins.ce;
  endproperty
  a_rd_sel: assert property (p_rd_sel)
    else $error("read not selected");
  property p_march_data;
    !mode_q && !sram_pins.we_n |-> sram_pins.dout inside {8'h00, 8'hFF};
  endproperty
  a_march_data: assert property (p_march_data)
    else $error("march write data not true or complement");
  property p_cb_data;
    mode_q && !sram_pins.we_n |-> (sram_pins.dout
      ^ ((sram_pins.addr[WALK_W-ROW_W] ^ sram_pins.addr[0]) ? 8'hAA : 8'h55))
      inside {8'h00, 8'hFF};
  endproperty
  a_cb_data: assert property (p_cb_data)
    else $error("checkerboard data wrong");
  property p_cb_order;
    mode_q && $fell(sram_pins.we_n) && sram_pins.ce && sram_pins.addr != 0
      |-> sram_pins.addr == wa_q + 17'h1;
  endproperty
  a_cb_order: assert property (p_cb_order)
    else $error("checkerboard write not ascending");

  // ==========
  // coverage of the main runs
  c_march: cover property (!busy && start && !test_sel);
  c_desel: cover property (!busy && start && test_sel);
  c_write: cover property ($fell(sram_pins.we_n));
  c_done: cover property (done && !fail);
  c_fail: cover property (done && fail);
endmodule : smt_march_gen_properties

bind smt_march_gen smt_march_gen_properties #(
  .ROW_W(ROW_W),
  .WALK_W(WALK_W)
) u_smt_march_gen_properties (
  .clk(clk), .srst(srst), .start(start), .test_sel(test_sel),
  .sram_din(sram_din), .sram_pins(sram_pins), .busy(busy), .done(done),
  .fail(fail), .fail_addr(fail_addr), .fail_data(fail_data)
);

//--- tb/smt_march_gen_test.sv
// self-checking bench for the sram pattern generator
`timescale 1ns/1ns
`include "smt_params.svh"
module smt_march_gen_test;
  import smt_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic test_sel = 1'b0;
  logic [`SMT_DATA_W-1:0] sram_din;
  smt_pins_t sram_pins;
  logic busy, done, fail;
  logic [`SMT_ADDR_W-1:0] fail_addr;
  logic [`SMT_DATA_W-1:0] fail_data;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic flip_en = 1'b0;
  logic [`SMT_ADDR_W-1:0] flip_addr = 17'h0;

  // 100 ns clock
  always #50 clk = ~clk;

  // a 256-word walk keeps full runs short; seven column bits as in the
  // full array, so the checkerboard parity bit stays at address bit 7
  smt_march_gen #(
    .ROW_W(1),
    .WALK_W(8)
  ) u_smt_march_gen (
    .clk(clk), .srst(srst), .start(start), .test_sel(test_sel),
    .sram_din(sram_din), .sram_pins(sram_pins), .busy(busy), .done(done),
    .fail(fail), .fail_addr(fail_addr), .fail_data(fail_data)
  );
  smt_sram_model u_smt_sram_model (
    .pins(sram_pins), .flip_en(flip_en), .flip_addr(flip_addr),
    .rdata(sram_din)
  );

  // ==========
  // shared tasks
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %0h got %0h", what, exp, got);
    end
  endtask : chk

  // take a run; busy must rise on the edge after the take
  task automatic go(logic sel);
    test_sel = sel;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    chk("busy", 17'h1, {16'h0, busy});
  endtask : go

  // bounded wait for the next write strobe, then step past it
  task automatic next_wr(output logic [16:0] a, output logic [7:0] d);
    int n;
    n = 0;
    while (sram_pins.we_n !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    a = sram_pins.addr;
    d = sram_pins.dout;
    repeat (2) @(negedge clk);
  endtask : next_wr

  // mid-run reset must drop everything to idle
  task automatic rst_mid;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk("busy after reset", 17'h0, {16'h0, busy});
    chk("ce after reset", 17'h0, {16'h0, sram_pins.ce});
  endtask : rst_mid

  // ==========
  // scenarios
  // background fill: zeros, ascending; a start while busy changes nothing
  task automatic t_march_bg;
    logic [16:0] a;
    logic [7:0] d;
    go(1'b0);
    for (int i = 0; i < 6; i++) begin
      if (i == 2)
        start = 1'b1;
      next_wr(a, d);
      start = 1'b0;
      test_sel = 1'b1;
      chk("bg addr", 17'(i), a);
      chk("bg data", 17'h0, {9'h0, d});
    end
    rst_mid();
    $display("march background test finished");
  endtask : t_march_bg

  // checkerboard fill across a row boundary
  task automatic t_cb;
    logic [16:0] a;
    logic [7:0] d;
    logic [7:0] e;
    go(1'b1);
    for (int i = 0; i < 130; i++) begin
      next_wr(a, d);
      e = (i[7] ^ i[0]) ? 8'hAA : 8'h55;
      chk("cb addr", 17'(i), a);
      chk("cb data", {9'h0, e}, {9'h0, d});
    end
    rst_mid();
    $display("checkerboard fill test finished");
  endtask : t_cb

  // full run up to the done pulse; four cycles per access, plus two
  task automatic run(logic sel, logic [16:0] exp_cyc);
    int n;
    n = 2;
    go(sel);
    chk("fail cleared", 17'h0, {16'h0, fail});
    while (done !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk("run cycles", exp_cyc, 17'(n));
    chk("busy at done", 17'h0, {16'h0, busy});
    @(negedge clk);
    chk("done pulse", 17'h0, {16'h0, done});
  endtask : run

  // full march over 256 words, 14 accesses each: every read matches
  task automatic t_march;
    run(1'b0, 17'h3802);
    chk("march fail", 17'h0, {16'h0, fail});
    $display("march run test finished");
  endtask : t_march

  // deselect test clean, then with one cell reading back wrong
  task automatic t_desel;
    run(1'b1, 17'h1802);
    chk("desel fail", 17'h0, {16'h0, fail});
    flip_addr = 17'h81;
    flip_en = 1'b1;
    run(1'b1, 17'h1802);
    flip_en = 1'b0;
    chk("fault flag", 17'h1, {16'h0, fail});
    chk("fault addr", 17'h81, fail_addr);
    chk("fault data", 17'h54, {9'h0, fail_data});
    $display("deselect run test finished");
  endtask : t_desel

  // ==========
  // hang guard, then main sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    t_march_bg();
    t_cb();
    t_desel();
    t_march();
    test_done();
  end
endmodule : smt_march_gen_test

//--- tb/smt_sram_model.sv
// behavioural 128k x 8 sram seen from its pins
`timescale 1ns/1ns
`include "smt_params.svh"
module smt_sram_model
  import smt_pkg::*;
(
  input wire smt_pins_t pins,
  input wire logic flip_en,
  input wire logic [`SMT_ADDR_W-1:0] flip_addr,
  output logic [`SMT_DATA_W-1:0] rdata
);
  // full word range, so every 17-bit address is a distinct cell
  logic [`SMT_DATA_W-1:0] mem_q [0:(1<<`SMT_ADDR_W)-1];
  logic [`SMT_DATA_W-1:0] last_q = 8'h00;
  logic sel;

  assign sel = !pins.cs_n && pins.ce;

  // a write lands at the end of the strobe and only while selected
  always @(posedge pins.we_n) begin
    if (sel && pins.doe)
      mem_q[pins.addr] = pins.dout;
  end

  // remember the last driven value when the output is released
  always @(posedge pins.oe_n) begin
    last_q = mem_q[pins.addr];
  end

  // released bus shows the inverse, never a stale copy that could pass
  always @* begin
    // one chosen cell can read back with bit 0 flipped, to prove the check
    if (sel && !pins.oe_n && pins.we_n)
      rdata = mem_q[pins.addr] ^ {7'h0, flip_en && pins.addr == flip_addr};
    else
      rdata = ~last_q;
  end
endmodule : smt_sram_model

//--- verilog/smt_march_gen.sv
// pattern generator driving a 128k x 8 sram through its pins
//
// Notes on behaviour
// - background zeros written, ascending addresses first
// - element one: ascending y-fast, read, write complement, read
// - element two: descending x-fast from top, complement to true
// - element three: from zero, descending y-fast, true to complement
// - element four: from top, ascending x-fast, complement to true
// - final background read, descending y-fast
// - checkerboard written selected, ascending from zero
// - deselected inverse write, then ascending readback
// - second pass with patterns swapped
// - row and column split gives topological order
`timescale 1ns/1ns
`include "smt_params.svh"
module smt_march_gen
  import smt_pkg::*;
#(
  parameter int ROW_W = `SMT_ROW_W,
  parameter int WALK_W = `SMT_ADDR_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic test_sel,
  input wire logic [`SMT_DATA_W-1:0] sram_din,
  output smt_pins_t sram_pins,
  output logic busy,
  output logic done,
  output logic fail,
  output logic [`SMT_ADDR_W-1:0] fail_addr,
  output logic [`SMT_DATA_W-1:0] fail_data
);
  // ==========================================================
  // constants and checks
  localparam int ADDR_W = `SMT_ADDR_W;
  localparam int DATA_W = `SMT_DATA_W;
  localparam int ACC = `SMT_ACC_CYC;
  localparam logic [3:0] STB_END = 4'(ACC + 1);
  localparam logic [3:0] REL = 4'(ACC + 2);
  localparam logic [DATA_W-1:0] BG = `SMT_BG_DATA;
  localparam logic [DATA_W-1:0] CB = `SMT_CB_BASE;
  // last word of the walked range; address bits above it stay low
  localparam logic [ADDR_W-1:0] TOP = {ADDR_W{1'b1}} >> (ADDR_W - WALK_W);

  // walked range must fit the pins; row split leaves a column bit
  if (WALK_W < 2 || WALK_W > ADDR_W) begin : g_bad_walk
    $error("WALK_W must lie between 2 and ADDR_W");
  end
  if (ROW_W < 1 || ROW_W >= WALK_W) begin : g_bad_row
    $error("ROW_W must lie between 1 and WALK_W-1");
  end
  if (ACC < 1 || ACC > 12) begin : g_bad_acc
    $error("access cycle count out of range");
  end

  // ==========================================================
  // state
  smt_phase_t phase_q;
  logic [1:0] op_q;
  logic [3:0] step_q;
  logic [ADDR_W-1:0] idx_q;
  logic [ADDR_W-1:0] cnt_q;
  logic swap_q;
  smt_pins_t pins_q;
  logic busy_q;
  logic done_q;
  logic fail_q;
  logic [ADDR_W-1:0] fail_addr_q;
  logic [DATA_W-1:0] fail_data_q;

  // ==========================================================
  // walk of each phase
  function automatic smt_walk_t walk_of(smt_phase_t p);
    smt_walk_t w;
    w = '{yfast: 1'b0, desc: 1'b0, start_hi: 1'b0, last_op: 2'h0};
    unique case (p)
      SMT_BG_WR: w.last_op = 2'h0;
      SMT_M1: w = '{1'b1, 1'b0, 1'b0, 2'h2};
      SMT_M2: w = '{1'b0, 1'b1, 1'b1, 2'h2};
      SMT_M3: w = '{1'b1, 1'b1, 1'b0, 2'h2};
      SMT_M4: w = '{1'b0, 1'b0, 1'b1, 2'h2};
      SMT_BG_RD: w = '{1'b1, 1'b1, 1'b1, 2'h0};
      SMT_CB_WR, SMT_CB_DES, SMT_CB_RD: w.last_op = 2'h0;
      SMT_IDLE, SMT_DONE: w.last_op = 2'h0;
    endcase
    return w;
  endfunction : walk_of

  // phase that follows the last word of the current one
  function automatic smt_phase_t next_of(smt_phase_t p, logic swp);
    smt_phase_t n;
    n = SMT_DONE;
    unique case (p)
      SMT_BG_WR: n = SMT_M1;
      SMT_M1: n = SMT_M2;
      SMT_M2: n = SMT_M3;
      SMT_M3: n = SMT_M4;
      SMT_M4: n = SMT_BG_RD;
      SMT_BG_RD: n = SMT_DONE;
      SMT_CB_WR: n = SMT_CB_DES;
      SMT_CB_DES: n = SMT_CB_RD;
      SMT_CB_RD: n = swp ? SMT_DONE : SMT_CB_WR;
      SMT_IDLE, SMT_DONE: n = SMT_DONE;
    endcase
    return n;
  endfunction : next_of

  smt_walk_t walk_c;
  smt_walk_t nwalk_c;
  smt_phase_t nxt_c;
  logic [ADDR_W-1:0] addr_c;
  logic par_c;
  logic [DATA_W-1:0] cbv_c;
  logic op_wr_c;
  logic op_desel_c;
  logic [DATA_W-1:0] op_val_c;

  // ==========================================================
  // address mapping and patterns
  assign walk_c = walk_of(phase_q);
  assign nxt_c = next_of(phase_q, swap_q);
  assign nwalk_c = walk_of(nxt_c);
  // address is {row, col} inside the walked range; y-fast steps the
  // row bits fastest
  always_comb begin
    addr_c = '0;
    addr_c[WALK_W-1:0] = walk_c.yfast ?
        {idx_q[ROW_W-1:0], idx_q[WALK_W-1:ROW_W]} :
        idx_q[WALK_W-1:0];
  end
  assign par_c = addr_c[WALK_W-ROW_W] ^ addr_c[0];
  assign cbv_c = (par_c ^ swap_q) ? ~CB : CB;

  // ==========================================================
  // operation of the current step
  always_comb begin
    op_wr_c = 1'b0;
    op_desel_c = 1'b0;
    op_val_c = BG;
    unique case (phase_q)
      SMT_BG_WR: op_wr_c = 1'b1;
      SMT_BG_RD: op_val_c = BG;
      SMT_M1, SMT_M3: begin
        op_wr_c = (op_q == 2'h1);
        op_val_c = (op_q == 2'h0) ? BG : ~BG;
      end
      SMT_M2, SMT_M4: begin
        op_wr_c = (op_q == 2'h1);
        op_val_c = (op_q == 2'h0) ? ~BG : BG;
      end
      SMT_CB_WR: begin
        op_wr_c = 1'b1;
        op_val_c = cbv_c;
      end
      SMT_CB_DES: begin
        op_wr_c = 1'b1;
        op_desel_c = 1'b1;
        op_val_c = ~cbv_c;
      end
      SMT_CB_RD: op_val_c = cbv_c;
      SMT_IDLE, SMT_DONE: op_val_c = BG;
    endcase
  end

  // ==========================================================
  // sequencing: phase, op, access step and address walk
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= SMT_IDLE;
      op_q <= 2'h0;
      step_q <= 4'h0;
      idx_q <= '0;
      cnt_q <= '0;
      swap_q <= 1'b0;
    end else begin
      unique case (phase_q)
        SMT_IDLE: begin
          // both first phases start at word zero going up
          if (start) begin
            phase_q <= test_sel ? SMT_CB_WR : SMT_BG_WR;
            swap_q <= 1'b0;
            op_q <= 2'h0;
            step_q <= 4'h0;
            idx_q <= '0;
            cnt_q <= '0;
          end
        end
        SMT_DONE: phase_q <= SMT_IDLE;
        SMT_BG_WR, SMT_M1, SMT_M2, SMT_M3, SMT_M4, SMT_BG_RD,
        SMT_CB_WR, SMT_CB_DES, SMT_CB_RD: begin
          if (step_q != REL) begin
            step_q <= step_q + 4'h1;
          end else begin
            step_q <= 4'h0;
            if (op_q != walk_c.last_op) begin
              op_q <= op_q + 2'h1;
            end else begin
              op_q <= 2'h0;
              // every word visited once, wrapping past the end
              if (cnt_q == TOP) begin
                cnt_q <= '0;
                phase_q <= nxt_c;
                idx_q <= nwalk_c.start_hi ? TOP : '0;
                if (phase_q == SMT_CB_RD) begin
                  swap_q <= 1'b1;
                end
              end else begin
                cnt_q <= cnt_q + 1'b1;
                // masked so the walk wraps inside the walked range
                idx_q <= (walk_c.desc ? idx_q - 1'b1 : idx_q + 1'b1) & TOP;
              end
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // pin drive: setup, strobe for the access time, then release
  // data stays driven through release so write hold is kept
  always_ff @(posedge clk) begin
    if (srst) begin
      pins_q <= '{addr: '0, dout: '0, doe: 1'b0, we_n: 1'b1,
                  oe_n: 1'b1, cs_n: 1'b1, ce: 1'b0};
    end else if (phase_q == SMT_IDLE || phase_q == SMT_DONE) begin
      pins_q.doe <= 1'b0;
      pins_q.we_n <= 1'b1;
      pins_q.oe_n <= 1'b1;
      pins_q.cs_n <= 1'b1;
      pins_q.ce <= 1'b0;
    end else if (step_q == 4'h0) begin
      pins_q.addr <= addr_c;
      pins_q.dout <= op_val_c;
      pins_q.doe <= op_wr_c;
      pins_q.we_n <= 1'b1;
      pins_q.oe_n <= 1'b1;
      pins_q.cs_n <= 1'b0;
      pins_q.ce <= ~op_desel_c;
    end else if (step_q == 4'h1) begin
      pins_q.we_n <= ~op_wr_c;
      pins_q.oe_n <= op_wr_c;
    end else if (step_q == REL) begin
      pins_q.we_n <= 1'b1;
      pins_q.oe_n <= 1'b1;
    end
  end

  // ==========================================================
  // read check: first mismatch is kept, later ones only keep fail
  always_ff @(posedge clk) begin
    if (srst) begin
      fail_q <= 1'b0;
      fail_addr_q <= '0;
      fail_data_q <= '0;
    end else if (phase_q == SMT_IDLE && start) begin
      fail_q <= 1'b0;
    end else if (phase_q != SMT_IDLE && phase_q != SMT_DONE &&
                 !op_wr_c && step_q == STB_END &&
                 sram_din != op_val_c) begin
      fail_q <= 1'b1;
      if (!fail_q) begin
        fail_addr_q <= pins_q.addr;
        fail_data_q <= sram_din;
      end
    end
  end

  // ==========================================================
  // status
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (phase_q == SMT_IDLE && start) begin
        busy_q <= 1'b1;
      end else if (phase_q == SMT_DONE) begin
        busy_q <= 1'b0;
      end
      done_q <= (phase_q == SMT_DONE);
    end
  end

  assign sram_pins = pins_q;
  assign busy = busy_q;
  assign done = done_q;
  assign fail = fail_q;
  assign fail_addr = fail_addr_q;
  assign fail_data = fail_data_q;
endmodule : smt_march_gen

//--- verilog/smt_params.svh
// constants for the sram march and deselect pattern generator
`ifndef SMT_PARAMS_SVH
`define SMT_PARAMS_SVH
// ==========================================================
// array geometry
`define SMT_ADDR_W 17
`define SMT_DATA_W 8
`define SMT_ROW_W 10
// ==========================================================
// data patterns
`define SMT_BG_DATA 8'h00
`define SMT_CB_BASE 8'h55
// ==========================================================
// timing
`define SMT_CLK_NS 100
`define SMT_T_ACC_NS 25
`define SMT_ACC_CYC ((`SMT_T_ACC_NS + `SMT_CLK_NS - 1) / `SMT_CLK_NS)
`endif

//--- verilog/smt_pkg.sv
// types for the sram march and deselect pattern generator
`include "smt_params.svh"
package smt_pkg;
  // ==========================================================
  // sequence phases
  typedef enum logic [3:0] {
    SMT_IDLE, SMT_BG_WR, SMT_M1, SMT_M2, SMT_M3, SMT_M4, SMT_BG_RD,
    SMT_CB_WR, SMT_CB_DES, SMT_CB_RD, SMT_DONE
  } smt_phase_t;

  // pins driven toward the sram
  typedef struct packed {
    logic [`SMT_ADDR_W-1:0] addr;
    logic [`SMT_DATA_W-1:0] dout;
    logic doe;
    logic we_n;
    logic oe_n;
    logic cs_n;
    logic ce;
  } smt_pins_t;

  // address walk of one phase
  typedef struct packed {
    logic yfast;
    logic desc;
    logic start_hi;
    logic [1:0] last_op;
  } smt_walk_t;
endpackage : smt_pkg
